// >>> design/scs_defines.svh
// Purpose: offsets, fields, reset values and timing counts of the startup clock supervisor
// Assumes: 100 MHz reference clock on clk_in
// Notes:   included by bare name
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

`define SCS_CLK_KHZ            100000
`define SCS_CQ_TIMEOUT_MS      500
`define SCS_CQ_TIMEOUT_CYC     (`SCS_CQ_TIMEOUT_MS * `SCS_CLK_KHZ)
`define SCS_QC_EDGES           13'h1000
`define SCS_STARTUP_EDGES      8'hc0
`define SCS_MIN_RESET_EDGES    2'h2
`define SCS_MON_FAIL_KHZ       100
`define SCS_MON_FAIL_CYC       (`SCS_CLK_KHZ / `SCS_MON_FAIL_KHZ)
`define SCS_WAKE_RECOVERY_CYC  8'h0e

`define SCS_ADDR_FLAGS         2'h0
`define SCS_ADDR_MASK          2'h1
`define SCS_ADDR_CTRL          2'h2
`define SCS_ADDR_STATUS        2'h3

`define SCS_FLAG_POR           0
`define SCS_FLAG_LVR           1
`define SCS_FLAG_EXT           2
`define SCS_FLAG_MONFAIL       3
`define SCS_FLAG_SELFCLK       4
`define SCS_FLAG_LVI           5
`define SCS_FLAG_QCPASS        6
`define SCS_NFLAGS             7

`define SCS_CTRL_MON_EN        0
`define SCS_CTRL_PSTOP         1
`define SCS_CTRL_RESET         2'h1
`define SCS_MASK_RESET         7'h00

`endif

// >>> design/scs_pkg.sv
// Purpose: types of the startup clock supervisor
// Assumes: nothing
// Notes:   gray codes along reset, check, startup, run
package scs_pkg;
  typedef enum logic [2:0] {
    SCS_RESET   = 3'h0,
    SCS_QUALITY = 3'h1,
    SCS_STARTUP = 3'h3,
    SCS_RUN     = 3'h2,
    SCS_PSTOP   = 3'h6,
    SCS_WAKE    = 3'h7,
    SCS_FSTOP   = 3'h5
  } scs_state_t;
  typedef logic [6:0] scs_flags_t;
endpackage : scs_pkg

// >>> design/scs_osc_tracker.sv
// Purpose: synchronise the oscillator pin, give an edge pulse and a slow-clock alarm
// Assumes: oscillator below half of clk_in
// Notes:   the alarm window restarts on every rising oscillator edge
`timescale 1ns/1ps
`include "scs_defines.svh"
module scs_osc_tracker (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic osc_in,
  input  wire logic enable_in,
  output logic      edge_out,
  output logic      slow_out
);
  localparam int unsigned MON_CYC = `SCS_MON_FAIL_CYC;
  logic        sync_a;
  logic        sync_b;
  logic        last;
  logic [10:0] gap;
  wire         rise = sync_b & ~last;
  wire         gap_full = (gap >= 11'(MON_CYC - 1));

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      last   <= 1'b0;
    end else begin
      sync_a <= osc_in;
      sync_b <= sync_a;
      last   <= sync_b;
    end
  end

  // no edge for one period of the fail frequency means the clock is too slow
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap <= 11'h000;
    end else if (!enable_in || rise) begin
      gap <= 11'h000;
    end else if (!gap_full) begin
      gap <= gap + 11'h001;
    end
  end

  assign edge_out = rise;
  assign slow_out = enable_in & gap_full;
endmodule : scs_osc_tracker

// >>> design/scs_supervisor.sv
// Purpose: reset and startup sequencing, oscillator quality check and clock monitor
// Assumes: clk_in is the self clock reference at 100 MHz; supply monitors are levels
// Notes:   register port: 2-bit address, 8-bit data, read data one cycle after the strobe
`timescale 1ns/1ps
`include "scs_defines.svh"
module scs_supervisor #(
  parameter int unsigned CQ_TIMEOUT_CYC = `SCS_CQ_TIMEOUT_CYC
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             osc_in,
  input  wire logic             por_in,
  input  wire logic             low_voltage_reset_detect_in,
  input  wire logic             low_voltage_interrupt_detect_in,
  input  wire logic             full_perf_in,
  input  wire logic             ext_reset_n_in,
  input  wire logic             osc_type_select_pin_in,
  input  wire logic             stop_req_in,
  input  wire logic             wait_req_in,
  input  wire logic             ext_irq_in,
  input  wire logic             int_irq_in,
  input  wire logic [1:0]       addr_in,
  input  wire logic [7:0]       wdata_in,
  input  wire logic             wr_in,
  input  wire logic             rd_in,
  output logic      [7:0]       rdata_out,
  output logic                  irq_out,
  output logic                  internal_reset_out,
  output logic                  osc_enable_out,
  output logic                  osc_full_swing_out,
  output logic                  quality_check_out,
  output logic                  self_clock_out,
  output logic                  sys_clk_from_osc_out,
  output logic                  pll_ref_from_osc_out,
  output logic                  cpu_run_out,
  output logic                  fetch_reset_vector_out,
  output logic                  fetch_irq_vector_out,
  output logic                  monitor_fail_out,
  output scs_pkg::scs_state_t   state_out
);
  import scs_pkg::*;

  // pin and monitor synchronisers
  logic [1:0] por_s;
  logic [1:0] lvr_s;
  logic [1:0] lvi_s;
  logic [1:0] fp_s;
  logic [1:0] xr_s;
  logic [1:0] sel_s;
  logic [1:0] eirq_s;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      por_s  <= 2'h3;
      lvr_s  <= 2'h0;
      lvi_s  <= 2'h0;
      fp_s   <= 2'h0;
      xr_s   <= 2'h3;
      sel_s  <= 2'h0;
      eirq_s <= 2'h0;
    end else begin
      por_s  <= {por_s[0], por_in};
      lvr_s  <= {lvr_s[0], low_voltage_reset_detect_in};
      lvi_s  <= {lvi_s[0], low_voltage_interrupt_detect_in};
      fp_s   <= {fp_s[0], full_perf_in};
      xr_s   <= {xr_s[0], ext_reset_n_in};
      sel_s  <= {sel_s[0], osc_type_select_pin_in};
      eirq_s <= {eirq_s[0], ext_irq_in};
    end
  end

  wire por_lvl = por_s[1];
  wire lvr_lvl = lvr_s[1] & fp_s[1];
  wire lvi_lvl = lvi_s[1] & fp_s[1];
  wire xr_low  = ~xr_s[1];
  wire eirq    = eirq_s[1];

  // state and working registers
  scs_state_t  state;
  scs_state_t  next_state;
  logic        self_clk;
  logic        osc_good;
  logic        osc_type;
  logic        cold_start;
  logic [1:0]  xr_edges;
  logic        xr_taken;
  logic [12:0] qc_edges;
  logic [25:0] qc_timer;
  logic [7:0]  su_edges;
  logic [7:0]  wake_cnt;
  logic        lvi_last;
  scs_flags_t  flags;
  scs_flags_t  mask;
  logic [1:0]  ctrl;
  logic [7:0]  rdata;

  logic osc_edge;
  logic osc_slow;

  scs_osc_tracker u_track (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .osc_in    (osc_in),
    .enable_in (osc_enable_out),
    .edge_out  (osc_edge),
    .slow_out  (osc_slow)
  );

  // reset sources
  wire supply_rst = por_lvl | lvr_lvl;
  wire xr_rst     = xr_taken;
  wire any_rst    = supply_rst | xr_rst;
  wire mon_fail   = ctrl[`SCS_CTRL_MON_EN] & osc_slow & (state == SCS_RUN) & ~self_clk;

  // quality check: enough edges before timeout passes, timeout fails
  wire in_qc     = (state == SCS_QUALITY);
  wire qc_pass   = in_qc & (qc_edges >= `SCS_QC_EDGES - 13'h001) & osc_edge;
  wire qc_tmo    = in_qc & ~qc_pass & (qc_timer >= 26'(CQ_TIMEOUT_CYC - 1));
  wire su_done   = (state == SCS_STARTUP) & osc_edge & (su_edges == `SCS_STARTUP_EDGES - 8'h01);
  wire wake_done = (state == SCS_WAKE) & (wake_cnt == `SCS_WAKE_RECOVERY_CYC - 8'h01);
  wire stop_full = stop_req_in & ~ctrl[`SCS_CTRL_PSTOP];
  wire any_irq   = eirq | int_irq_in;

  // external reset qualified by oscillator periods while the pin is low
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xr_edges <= 2'h0;
      xr_taken <= 1'b0;
    end else if (!xr_low) begin
      xr_edges <= 2'h0;
      xr_taken <= 1'b0;
    end else begin
      if (osc_edge && xr_edges != `SCS_MIN_RESET_EDGES) begin
        xr_edges <= xr_edges + 2'h1;
      end
      // without a running oscillator the synchronised level alone is taken
      if (xr_edges == `SCS_MIN_RESET_EDGES || !osc_good) begin
        xr_taken <= 1'b1;
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      SCS_RESET: begin
        if (!any_rst) begin
          next_state = (cold_start || !osc_good) ? SCS_QUALITY : SCS_STARTUP;
        end
      end
      SCS_QUALITY: begin
        if (qc_pass) begin
          next_state = SCS_STARTUP;
        end else if (qc_tmo) begin
          next_state = SCS_RUN;
        end
      end
      SCS_STARTUP: begin
        if (su_done) begin
          next_state = SCS_RUN;
        end
      end
      SCS_RUN: begin
        if (mon_fail) begin
          next_state = SCS_QUALITY;
        end else if (stop_full) begin
          next_state = SCS_FSTOP;
        end else if (stop_req_in || wait_req_in) begin
          next_state = SCS_PSTOP;
        end
      end
      SCS_FSTOP: begin
        if (eirq) begin
          next_state = SCS_QUALITY;
        end
      end
      SCS_PSTOP: begin
        if (any_irq) begin
          next_state = SCS_WAKE;
        end
      end
      SCS_WAKE: begin
        if (wake_done) begin
          next_state = SCS_RUN;
        end
      end
      default: begin
        next_state = SCS_RESET;
      end
    endcase
    if (any_rst) begin
      next_state = SCS_RESET;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= SCS_RESET;
    end else begin
      state <= next_state;
    end
  end

  // counters of the check, startup and wake phases
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      qc_edges <= 13'h0000;
      qc_timer <= 26'h0000000;
      su_edges <= 8'h00;
      wake_cnt <= 8'h00;
    end else begin
      qc_edges <= (in_qc && osc_edge) ? qc_edges + 13'h0001 : (in_qc ? qc_edges : 13'h0000);
      qc_timer <= in_qc ? qc_timer + 26'h0000001 : 26'h0000000;
      if (state != SCS_STARTUP) begin
        su_edges <= 8'h00;
      end else if (osc_edge) begin
        su_edges <= su_edges + 8'h01;
      end
      wake_cnt <= (state == SCS_WAKE) ? wake_cnt + 8'h01 : 8'h00;
    end
  end

  // clock source and oscillator bookkeeping
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      self_clk   <= 1'b0;
      osc_good   <= 1'b0;
      osc_type   <= 1'b0;
      cold_start <= 1'b1;
    end else begin
      if (state == SCS_RESET) begin
        osc_type <= sel_s[1];
      end
      if (supply_rst) begin
        cold_start <= 1'b1;
        osc_good   <= 1'b0;
        self_clk   <= 1'b0;
      end else if (qc_pass) begin
        cold_start <= 1'b0;
        osc_good   <= 1'b1;
        self_clk   <= 1'b0;
      end else if (qc_tmo) begin
        cold_start <= 1'b0;
        self_clk   <= 1'b1;
      end else if (mon_fail || state == SCS_FSTOP) begin
        osc_good <= 1'b0;
      end
    end
  end

  // sticky flags, read of the flags register clears them, a set wins
  wire             rd_flags = rd_in & (addr_in == `SCS_ADDR_FLAGS);
  wire             lvi_rise = lvi_lvl & ~lvi_last;
  wire scs_flags_t set_vec  = {qc_pass, lvi_rise, qc_tmo, mon_fail,
                               xr_rst & ~supply_rst, lvr_lvl & ~por_lvl, por_lvl};

  genvar g;
  generate
    for (g = 0; g < `SCS_NFLAGS; g++) begin : g_flag
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          flags[g] <= 1'b0;
        end else if (set_vec[g]) begin
          flags[g] <= 1'b1;
        end else if (rd_flags) begin
          flags[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lvi_last <= 1'b0;
    end else begin
      lvi_last <= lvi_lvl;
    end
  end

  // register writes and read data
  wire [7:0] status_word = {2'h0, state, osc_good, osc_type, self_clk};
  wire [7:0] read_mux    = (addr_in == `SCS_ADDR_FLAGS) ? {1'b0, flags} :
                           (addr_in == `SCS_ADDR_MASK)  ? {1'b0, mask}  :
                           (addr_in == `SCS_ADDR_CTRL)  ? {6'h00, ctrl} : status_word;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask  <= `SCS_MASK_RESET;
      ctrl  <= `SCS_CTRL_RESET;
      rdata <= 8'h00;
    end else begin
      if (wr_in && addr_in == `SCS_ADDR_MASK) begin
        mask <= wdata_in[6:0];
      end
      if (wr_in && addr_in == `SCS_ADDR_CTRL) begin
        ctrl <= wdata_in[1:0];
      end
      rdata <= rd_in ? read_mux : 8'h00;
    end
  end

  // outputs
  logic fetch_rst_q;
  logic fetch_irq_q;
  logic int_rst_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fetch_rst_q <= 1'b0;
      fetch_irq_q <= 1'b0;
      int_rst_q   <= 1'b1;
    end else begin
      // reset vector after startup, or straight away on the self clock
      fetch_rst_q <= su_done | qc_tmo;
      fetch_irq_q <= wake_done | (state == SCS_QUALITY && qc_pass && !cold_start);
      int_rst_q   <= (next_state == SCS_RESET) | (next_state == SCS_QUALITY && cold_start)
                     | (next_state == SCS_STARTUP && state != SCS_QUALITY && cold_start);
    end
  end

  assign rdata_out              = rdata;
  assign irq_out                = |(flags & mask);
  assign internal_reset_out     = int_rst_q;
  assign osc_enable_out         = (state != SCS_RESET || !supply_rst) && state != SCS_FSTOP;
  assign osc_full_swing_out     = osc_type;
  assign quality_check_out      = in_qc;
  assign self_clock_out         = self_clk;
  assign sys_clk_from_osc_out   = ~self_clk & osc_good;
  assign pll_ref_from_osc_out   = osc_enable_out;
  assign cpu_run_out            = (state == SCS_RUN);
  assign fetch_reset_vector_out = fetch_rst_q;
  assign fetch_irq_vector_out   = fetch_irq_q;
  assign monitor_fail_out       = flags[`SCS_FLAG_MONFAIL];
  assign state_out              = state;
endmodule : scs_supervisor

// >>> sim/scs_osc_model.sv
// Purpose: oscillator source facing the supervisor's oscillator pin
// Assumes: square wave well below half of clk_in, phase unrelated to it
// Notes:   the pin stands still low while disabled or dead
`timescale 1ns/1ps
module scs_osc_model #(
  parameter real HALF_NS = 21.0
) (
  input  wire logic enable_in,
  input  wire logic dead_in,
  output logic      osc_out
);
  // dead models a failed crystal: no edges at all
  always begin
    #(HALF_NS);
    if (enable_in === 1'b1 && dead_in !== 1'b1) begin
      osc_out = ~osc_out;
    end else begin
      osc_out = 1'b0;
    end
  end
endmodule : scs_osc_model

// >>> sim/scs_checker_assertions.sv
// Purpose: port-level checks of the startup clock supervisor
// Assumes: one clock domain, bound from the bench
// Notes:   the lengths of a quality check and of a wake are counted in helper logic
`timescale 1ns/1ps
module scs_checker
  import scs_pkg::*;
#(
  parameter int unsigned CQ_TIMEOUT_CYC = 20000
) (
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       osc_enable_out,
  input wire logic       quality_check_out,
  input wire logic       self_clock_out,
  input wire logic       sys_clk_from_osc_out,
  input wire logic       pll_ref_from_osc_out,
  input wire logic       monitor_fail_out,
  input wire scs_state_t state_out
);
  logic [31:0] qc_cyc;
  logic [7:0]  wake_cyc;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      qc_cyc   <= 32'h0;
      wake_cyc <= 8'h00;
    end else begin
      qc_cyc   <= (state_out == SCS_QUALITY) ? qc_cyc + 32'h1 : 32'h0;
      wake_cyc <= (state_out == SCS_WAKE) ? wake_cyc + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_qc_osc; quality_check_out |-> osc_enable_out; endproperty
  a_qc_osc: assert property (p_qc_osc) else $error("osc off in check");
  property p_qc_len; qc_cyc <= CQ_TIMEOUT_CYC + 4; endproperty
  a_qc_len: assert property (p_qc_len) else $error("check too long");
  property p_qc_self;
    $past(state_out) == SCS_QUALITY && state_out == SCS_RUN |-> ##[0:1] self_clock_out;
  endproperty
  a_qc_self: assert property (p_qc_self) else $error("no self clock");
  property p_su_exit;
    $past(state_out) == SCS_STARTUP && state_out != SCS_STARTUP
      |-> state_out inside {SCS_RUN, SCS_RESET};
  endproperty
  a_su_exit: assert property (p_su_exit) else $error("bad startup exit");
  property p_fs_exit;
    $past(state_out) == SCS_FSTOP && state_out != SCS_FSTOP
      |-> state_out inside {SCS_QUALITY, SCS_RESET};
  endproperty
  a_fs_exit: assert property (p_fs_exit) else $error("stop wake skips check");
  property p_fs_osc; state_out == SCS_FSTOP |-> !osc_enable_out; endproperty
  a_fs_osc: assert property (p_fs_osc) else $error("osc on in stop");
  // wake_cyc holds the number of wake cycles already completed
  property p_wake;
    $past(state_out) == SCS_WAKE && state_out != SCS_WAKE
      |-> state_out == SCS_RUN && wake_cyc == 8'h0e;
  endproperty
  a_wake: assert property (p_wake) else $error("wake time wrong");
  property p_wake_max; state_out == SCS_WAKE |-> wake_cyc < 8'h0e; endproperty
  a_wake_max: assert property (p_wake_max) else $error("wake too long");
  property p_mon; $rose(monitor_fail_out) |-> ##[0:2] state_out == SCS_QUALITY; endproperty
  a_mon: assert property (p_mon) else $error("fail without check");
  property p_self_sys; self_clock_out |-> !sys_clk_from_osc_out; endproperty
  a_self_sys: assert property (p_self_sys) else $error("osc on sys clk");
  property p_ref; pll_ref_from_osc_out == osc_enable_out; endproperty
  a_ref: assert property (p_ref) else $error("pll ref wrong");
  property p_rd0; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside slot");
endmodule : scs_checker

// >>> sim/tb_top.sv
// Purpose: self-checking bench of the startup clock supervisor
// Assumes: 100 MHz clk_in, oscillator model near 24 MHz
// Notes:   quality timeout shortened to 20000 cycles
`timescale 1ns/1ps
module tb_top;
  import scs_pkg::*;
  localparam int unsigned CQ = 20000;
  logic clk_in = 1'b0, rst_n_in = 1'b0, osc_in, por_in = 1'b1, osc_dead = 1'b0;
  logic low_voltage_reset_detect_in = 1'b0, low_voltage_interrupt_detect_in = 1'b0;
  logic full_perf_in = 1'b1, ext_reset_n_in = 1'b1, osc_type_select_pin_in = 1'b0;
  logic stop_req_in = 1'b0, wait_req_in = 1'b0, ext_irq_in = 1'b0, int_irq_in = 1'b0;
  logic [1:0] addr_in = 2'h0;
  logic [7:0] wdata_in = 8'h00, rdata_out;
  logic wr_in = 1'b0, rd_in = 1'b0, irq_out, internal_reset_out, osc_enable_out;
  logic osc_full_swing_out, quality_check_out, self_clock_out, sys_clk_from_osc_out;
  logic pll_ref_from_osc_out, cpu_run_out, fetch_reset_vector_out, fetch_irq_vector_out;
  logic monitor_fail_out;
  scs_state_t state_out;
  int miscompares = 0, total_checks = 0, cyc = 0, oscn = 0, frn = 0, fin = 0, qcn = 0;
  int n, i, j;
  scs_supervisor #(.CQ_TIMEOUT_CYC(CQ)) u_dut (.clk_in, .rst_n_in, .osc_in, .por_in,
    .low_voltage_reset_detect_in, .low_voltage_interrupt_detect_in, .full_perf_in,
    .ext_reset_n_in, .osc_type_select_pin_in, .stop_req_in, .wait_req_in, .ext_irq_in,
    .int_irq_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_out,
    .internal_reset_out, .osc_enable_out, .osc_full_swing_out, .quality_check_out,
    .self_clock_out, .sys_clk_from_osc_out, .pll_ref_from_osc_out, .cpu_run_out,
    .fetch_reset_vector_out, .fetch_irq_vector_out, .monitor_fail_out, .state_out);
  scs_osc_model u_osc (.enable_in(osc_enable_out), .dead_in(osc_dead), .osc_out(osc_in));
  always #5 clk_in = ~clk_in;
  always @(posedge osc_in) oscn++;
  always @(posedge clk_in) begin
    cyc++;
    frn += (fetch_reset_vector_out === 1'b1);
    fin += (fetch_irq_vector_out === 1'b1);
    qcn += (quality_check_out === 1'b1);
    if (cyc == 90000) begin
      miscompares++;
      results();
    end
  end
  task automatic results();
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    check(rdata_out, exp);
  endtask : rd
  task automatic wait_st(input scs_state_t s, input int lim);
    int k;
    k = 0;
    while (state_out !== s && k < lim) begin
      @(posedge clk_in);
      #1;
      k++;
    end
    check(8'(state_out), 8'(s));
  endtask : wait_st
  initial begin
    void'($urandom(9847));
    repeat (3) @(posedge clk_in);
    osc_type_select_pin_in <= 1'($urandom);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    por_in <= 1'b0;
    wait_st(SCS_QUALITY, 20);
    check(osc_enable_out, 1'b1);
    check(osc_full_swing_out, osc_type_select_pin_in);
    wait_st(SCS_STARTUP, CQ);
    oscn = 0;
    wait_st(SCS_RUN, 1200);
    check(oscn >= 191 && oscn <= 197 && cpu_run_out, 1'b1);
    repeat (2) @(posedge clk_in);
    check(frn[7:0], 8'h01);
    check(pll_ref_from_osc_out && sys_clk_from_osc_out && !self_clock_out, 1'b1);
    rd(2'h0, 8'h41);
    wr(2'h0, 8'($urandom));
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h01);
    @(posedge clk_in);
    ext_reset_n_in <= 1'b0;
    repeat (16) @(posedge clk_in);
    check(internal_reset_out, 1'b1);
    n = qcn;
    ext_reset_n_in <= 1'b1;
    wait_st(SCS_RUN, 2000);
    check(8'(qcn - n), 8'h00);
    check(irq_out, 1'b0);
    wr(2'h1, 8'h04);
    check(irq_out, 1'b1);
    rd(2'h0, 8'h04);
    check(irq_out, 1'b0);
    check(frn[7:0], 8'h02);
    @(posedge clk_in);
    full_perf_in <= 1'b0;
    low_voltage_reset_detect_in <= 1'b1;
    low_voltage_interrupt_detect_in <= 1'b1;
    repeat ($urandom_range(30, 10)) @(posedge clk_in);
    check(8'(state_out), 8'(SCS_RUN));
    low_voltage_reset_detect_in <= 1'b0;
    low_voltage_interrupt_detect_in <= 1'b0;
    full_perf_in <= 1'b1;
    rd(2'h0, 8'h00);
    @(posedge clk_in);
    low_voltage_interrupt_detect_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    low_voltage_interrupt_detect_in <= 1'b0;
    rd(2'h0, 8'h20);
    for (i = 0; i < 2; i++) begin
      wr(2'h2, 8'h03);
      @(posedge clk_in);
      stop_req_in <= (i == 0);
      wait_req_in <= (i == 1);
      wait_st(SCS_PSTOP, 10);
      stop_req_in <= 1'b0;
      wait_req_in <= 1'b0;
      check(osc_enable_out, 1'b1);
      n = fin;
      int_irq_in <= (i == 0);
      ext_irq_in <= (i == 1);
      wait_st(SCS_WAKE, 10);
      j = 0;
      while (state_out === SCS_WAKE && j < 50) begin
        @(posedge clk_in);
        #1;
        j++;
      end
      check(j[7:0], 8'h0e);
      int_irq_in <= 1'b0;
      ext_irq_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      check(8'(fin - n), 8'h01);
    end
    wr(2'h2, 8'h01);
    @(posedge clk_in);
    stop_req_in <= 1'b1;
    wait_st(SCS_FSTOP, 10);
    stop_req_in <= 1'b0;
    int_irq_in <= 1'b1;
    repeat (30) @(posedge clk_in);
    check(8'(state_out), 8'(SCS_FSTOP));
    check(osc_enable_out, 1'b0);
    n = fin;
    int_irq_in <= 1'b0;
    ext_irq_in <= 1'b1;
    wait_st(SCS_QUALITY, 10);
    ext_irq_in <= 1'b0;
    wait_st(SCS_STARTUP, CQ);
    wait_st(SCS_RUN, 1200);
    repeat (2) @(posedge clk_in);
    check(8'(fin - n), 8'h01);
    rd(2'h0, 8'h40);
    @(posedge clk_in);
    osc_dead <= 1'b1;
    wait_st(SCS_QUALITY, 1200);
    check(monitor_fail_out, 1'b1);
    n = qcn;
    wait_st(SCS_RUN, CQ + 100);
    check(qcn - n >= CQ - 4, 1'b1);
    check(self_clock_out && !sys_clk_from_osc_out, 1'b1);
    rd(2'h0, 8'h18);
    results();
  end
endmodule : tb_top
bind scs_supervisor scs_checker #(.CQ_TIMEOUT_CYC(CQ_TIMEOUT_CYC)) u_chk (.clk_in, .rst_n_in,
  .rd_in, .rdata_out, .osc_enable_out, .quality_check_out, .self_clock_out,
  .sys_clk_from_osc_out, .pll_ref_from_osc_out, .monitor_fail_out, .state_out);
